// ---- dv/acdcs_host_model.sv ----
// serial bus master model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module acdcs_host_model #(
	parameter logic [6:0] ADDR = 7'h25 // arbitrary bus address
) (
	// clock
	input  wire logic clk_in,
	// bus pins, sda_in is the resolved wire
	input  wire logic sda_in,
	output var logic  scl_out,
	output var logic  sda_pull_out
);
	// ----------------------------------------------------------------
	// bit level
	// ----------------------------------------------------------------
	// bus idles with both lines released
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// quarter bit, so each scl phase lasts eight clocks
	task automatic qtr();
		repeat (4) @(posedge clk_in);
	endtask : qtr
	// data set while scl low, sampled in mid high
	task automatic bit_x(input logic b, output logic q);
		sda_pull_out <= !b;
		qtr();
		scl_out <= 1'b1;
		qtr();
		q = sda_in;
		qtr();
		scl_out <= 1'b0;
		qtr();
	endtask : bit_x
	// start and repeated start alike
	task automatic start();
		sda_pull_out <= 1'b0;
		qtr();
		scl_out <= 1'b1;
		qtr();
		sda_pull_out <= 1'b1;
		qtr();
		scl_out <= 1'b0;
		qtr();
	endtask : start
	task automatic stop();
		sda_pull_out <= 1'b1;
		qtr();
		scl_out <= 1'b1;
		qtr();
		sda_pull_out <= 1'b0;
		qtr();
		qtr();
	endtask : stop
	// ----------------------------------------------------------------
	// byte level
	// ----------------------------------------------------------------
	// whole byte msb first plus the ninth bit
	task automatic xfer(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(mack, ak);
	endtask : xfer
	task automatic addr(input logic [6:0] a, input logic r, output logic ak);
		logic [7:0] q;
		start();
		xfer({a, r}, 1'b1, q, ak);
	endtask : addr
	// pointer then one data byte
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		addr(ADDR, 1'b0, a0);
		xfer(p, 1'b1, q, a1);
		xfer(d, 1'b1, q, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask : wr
	// pointer, repeated start, one byte ended by nack
	task automatic rd(input logic [7:0] p, output logic [7:0] q);
		logic a;
		addr(ADDR, 1'b0, a);
		xfer(p, 1'b1, q, a);
		addr(ADDR, 1'b1, a);
		xfer(8'hFF, 1'b1, q, a);
		stop();
	endtask : rd
	// pointer, repeated start, two bytes with a master ack between them
	task automatic rd2(input logic [7:0] p, output logic [7:0] q0,
		output logic [7:0] q1);
		logic a;
		addr(ADDR, 1'b0, a);
		xfer(p, 1'b1, q0, a);
		addr(ADDR, 1'b1, a);
		xfer(8'hFF, 1'b0, q0, a);
		xfer(8'hFF, 1'b1, q1, a);
		stop();
	endtask : rd2
endmodule : acdcs_host_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the accessory detect control and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acdcs_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_in = 1'b0, rst_n_in = 1'b0, mask = 1'b1, ev = 1'b0, ack = 1'b0;
	logic [3:0]  sel = 4'h0;       // id stable time code
	acdcs_raw_t  raw = '0, r;       // detector results
	logic        scl, pull, oe, sda_o, rst_seen = 1'b0;
	logic        intn, jig_n, boot_n, chg_n, dis, ocp, sw1, sw2, ss, crst;
	logic [1:0]  ovp, flt;
	logic [4:0]  adc_s;
	logic [7:0]  v, w;
	logic        en = 1'b1;        // clock enable, low freezes the block
	int          failures = 0, check_count = 0, cyc = 0;
	wire         sda_line = !(pull | oe); // pull-up when nobody pulls
	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	// short counts keep the run brief
	acdcs_top #(.DEGL_CYC(16), .MS_CYC(20)) acdcs_top_inst (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(en),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(oe),
		.detect_raw_in(raw), .interrupt_mask_bit_in(mask), .int_event_in(ev),
		.int_ack_in(ack), .id_stable_sel_in(sel), .interrupt_n_out(intn),
		.factory_jig_n_out(jig_n), .boot_n_out(boot_n), .charger_detect_n_out(chg_n),
		.vbus_discharge_enable_out(dis), .overvoltage_threshold_select_out(ovp),
		.id_float_filter_time_out(flt), .id_fet_overcurrent_disable_out(ocp),
		.id_switch_one_on_out(sw1), .id_switch_two_on_out(sw2),
		.id_fet_soft_start_out(ss), .settled_adc_out(adc_s), .chip_reset_out(crst));
	acdcs_host_model acdcs_host_model_inst (
		.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_pull_out(pull));
	// ----------------------------------------------------------------
	// clock, watchdog, helpers
	// ----------------------------------------------------------------
	initial forever #4 clk_in = ~clk_in;
	// the reset pulse lasts one cycle, so latch it
	always @(posedge clk_in) begin
		if (crst === 1'b1) rst_seen <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		acdcs_host_model_inst.wr(a, d, ok);
		chk(8'(ok), 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		acdcs_host_model_inst.rd(a, q);
		chk(q, exp);
	endtask : rd
	task automatic put(input acdcs_raw_t x);
		@(posedge clk_in);
		raw <= x;
		repeat (6) @(posedge clk_in);
	endtask : put
	// one-cycle strobe on event or acknowledge
	task automatic pulse(input logic is_ev);
		@(posedge clk_in);
		if (is_ev) ev <= 1'b1;
		else ack <= 1'b1;
		@(posedge clk_in);
		ev <= 1'b0;
		ack <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : pulse
	task automatic final_report();
		if (failures == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic ak;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk(8'(intn), 8'h00);
		chk(8'({ovp, flt}), 8'h06);
		chk(8'(sda_o), 8'h00);
		rd(8'h10, 8'h18);
		rd(8'h11, 8'h03);
		acdcs_host_model_inst.rd2(8'h10, v, w);
		chk(v, 8'h18);
		chk(w, 8'h03);
		rd(8'h0F, 8'h00);
		rd(8'h20, 8'h00);
		wr(8'h12, 8'hFF);
		rd(8'h12, 8'h00);
		acdcs_host_model_inst.addr(7'h26, 1'b0, ak);
		acdcs_host_model_inst.stop();
		chk(8'(ak), 8'h01);
		// every threshold and filter code, reserved bits set
		for (int i = 0; i < 4; i++) begin
			v = {i[0], 1'b1, i[1:0], ~i[1:0], 2'b11};
			wr(8'h10, v);
			rd(8'h10, v & 8'hBC);
			chk(8'({dis, ovp, flt}), 8'({i[0], i[1:0], ~i[1:0]}));
		end
		wr(8'h11, 8'hFF);
		rd(8'h11, 8'h13);
		chk(8'(ocp), 8'h01);
		wr(8'h11, 8'h00);
		chk(8'(ocp), 8'h00);
		// every charger and id state code
		for (int i = 0; i < 8; i++) begin
			r = '0;
			r.usb = i[2:0];
			r.idst = i[1:0];
			r.fm = i[0];
			r.data_contact_timeout_flag = i[1];
			put(r);
			rd(8'h13, {1'b0, i[2:0], 2'b00, i[1:0]});
			rd(8'h12, {2'b00, i[0], (i == 4 || i == 5), i[1], 3'b000});
			chk(8'(chg_n), 8'(!(i == 4 || i == 5)));
		end
		// a short glitch must not set the fault flags
		r = '0;
		r.uv = 1'b1;
		r.ov = 1'b1;
		put(r);
		put('0);
		rd(8'h12, 8'h00);
		put(r);
		repeat (30) @(posedge clk_in);
		rd(8'h12, 8'h05);
		r = '0;
		r.adc = 5'h0A;
		put(r);
		// settled value read well inside the stable time
		rd(8'h18, 8'h00);
		rd(8'h12, 8'h00);
		repeat (1200) @(posedge clk_in);
		rd(8'h18, 8'h0A);
		sel <= 4'h1;
		r.adc = 5'h15;
		put(r);
		repeat (1700) @(posedge clk_in);
		chk(8'(adc_s), 8'h0A);
		repeat (600) @(posedge clk_in);
		chk(8'(adc_s), 8'h15);
		// interrupt arming, event, clear, suppression
		@(posedge clk_in);
		mask <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(8'(intn), 8'h01);
		pulse(1'b1);
		chk(8'(intn), 8'h00);
		pulse(1'b0);
		chk(8'(intn), 8'h01);
		mask <= 1'b1;
		pulse(1'b1);
		chk(8'(intn), 8'h01);
		mask <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(8'(intn), 8'h00);
		// self-clearing soft reset
		wr(8'h10, 8'h80);
		wr(8'h19, 8'h01);
		chk(8'(rst_seen), 8'h01);
		rd(8'h19, 8'h00);
		rd(8'h10, 8'h18);
		// factory mode drives jig, boot and the fet
		r = '0;
		r.fm = 1'b1;
		r.fet_req = 1'b1;
		r.jig_req = 1'b1;
		r.boot_req = 1'b1;
		put(r);
		chk(8'({jig_n, boot_n, sw1, sw2, ss}), 8'h07);
		repeat (700) @(posedge clk_in);
		chk(8'(ss), 8'h00);
		wr(8'h11, 8'h01);
		chk(8'({sw1, sw2}), 8'h01);
		r.fm = 1'b0;
		put(r);
		chk(8'({jig_n, boot_n, sw1, sw2}), 8'h0C);
		// a low enable freezes synchronisers and outputs alike
		en <= 1'b0;
		r.fm = 1'b1;
		put(r);
		chk(8'({jig_n, sw2}), 8'h02);
		en <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk(8'({jig_n, sw2}), 8'h01);
		final_report();
	end
endmodule : tb
`default_nettype wire

// ---- logic/acdcs_map.svh ----
// register map, field positions, reset values and timing constants
`ifndef ACDCS_MAP_SVH
`define ACDCS_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACDCS_A_DEV4   8'h0F
`define ACDCS_A_VCTL   8'h10
`define ACDCS_A_FCTL   8'h11
`define ACDCS_A_STS1   8'h12
`define ACDCS_A_STS2   8'h13
`define ACDCS_A_ADC    8'h18
`define ACDCS_A_RST    8'h19
// ----------------------------------------------------------------
// reset values, write masks, field positions
// ----------------------------------------------------------------
`define ACDCS_VCTL_RST  8'h18
`define ACDCS_VCTL_WM   8'hBC
`define ACDCS_FCTL_RST  8'h03
`define ACDCS_FCTL_WM   8'h13
`define ACDCS_VCTL_DIS  7
`define ACDCS_VCTL_OVP  5:4
`define ACDCS_VCTL_FLT  3:2
`define ACDCS_FCTL_OCP  4
`define ACDCS_FCTL_EN1  1
`define ACDCS_FCTL_EN2  0
`define ACDCS_RST_BIT   0
`define ACDCS_USB_DCP   3'h4
`define ACDCS_USB_CDP   3'h5
`define ACDCS_BITS      4'h8
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACDCS_CLK_NS    8
`define ACDCS_DEGL_NS   128000
`define ACDCS_MS_NS     1000000
`define ACDCS_SOFT_MS   6'h20
// id stable time in ms, entry 0 in the low 11 bits
`define ACDCS_STABLE_MS {11'h578, 11'h514, 11'h4B0, 11'h44C, 11'h3E8, 11'h384, \
	11'h320, 11'h2BC, 11'h258, 11'h1F4, 11'h190, 11'h12C, 11'h0C8, 11'h096, \
	11'h064, 11'h032}
`endif

// ---- logic/acdcs_pkg.sv ----
// types shared by the accessory detect control and status block
`default_nettype none
package acdcs_pkg;
	// raw detector results arriving from the analog side
	typedef struct packed {
		logic       uv;       // vbus undervoltage, undeglitched
		logic       ov;       // vbus overvoltage, undeglitched
		logic       fm;       // factory mode entered
		logic       data_contact_timeout_flag;     // data contact timeout seen
		logic [2:0] usb;      // charger detection result
		logic [1:0] idst;     // id detection state
		logic [4:0] adc;      // real-time id conversion
		logic       jig_req;  // jig wanted by detection
		logic       boot_req; // boot wanted by detection
		logic       fet_req;  // id to battery fet wanted
	} acdcs_raw_t;

	// serial slave states
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_WR, S_WACK, S_RD, S_RACK
	} acdcs_i2c_t;

	// whole state of the block
	typedef struct packed {
		acdcs_raw_t  s1;      // synchroniser first stage
		acdcs_raw_t  s2;      // synchroniser second stage
		logic [2:0]  scl;     // sync pair plus previous
		logic [2:0]  sda;     // sync pair plus previous
		acdcs_i2c_t  st;
		logic [3:0]  cnt;     // bit counter
		logic [7:0]  sh;      // receive shifter
		logic [7:0]  tx;      // transmit byte
		logic        rw;
		logic        nack;
		logic        oe;
		logic [7:0]  ptr;     // register pointer
		logic [7:0]  vctl;
		logic [7:0]  fctl;
		logic        rst_bit;
		logic [14:0] uv_cnt;
		logic [14:0] ov_cnt;
		logic        uv_f;
		logic        ov_f;
		logic [16:0] ms_div;
		logic [4:0]  adc_cand;
		logic [4:0]  adc_set;
		logic [10:0] stab_ms;
		logic        fet_on;
		logic [5:0]  ss_ms;
		logic        armed;
		logic        pend;
		logic        intn;
		logic        jig_n;
		logic        boot_n;
		logic        chg_n;
	} acdcs_state_t;
endpackage : acdcs_pkg
`default_nettype wire

// ---- logic/acdcs_top.sv ----
// accessory detect control and status registers with serial slave
// Operation
// - top control bit enables vbus discharge
// - two-bit field selects overvoltage trip level
// - two-bit field selects id float deglitch
// - one disables id fet overcurrent protection
// - switch enables open when zero, reset one
// - flags report factory mode and charger
// - flag reports data contact timeout
// - vbus fault flags need 128us deglitch
// - two-bit id detection state code
// - id resistance measured by 5-bit converter
// - settled conversion published after stable time
// - reset bit resets chip, clears itself
// - detect vbus, classify adapter by detection
// - switches and factory outputs follow detection
// - interrupt low until mask written zero
// - events pull armed interrupt low
// - jig and boot only in factory
// - charger output low for dcp/cdp
// - fet only in factory, 32ms soft-start
// - mask one holds armed interrupt high, event stays pending
// - stable time sixteen steps 50 to 1400ms
`timescale 1ns/1ps
`default_nettype none
`include "acdcs_map.svh"
module acdcs_top #(
	parameter logic [6:0] DEV_ADDR = 7'h25, // arbitrary bus address
	parameter int DEGL_CYC = `ACDCS_DEGL_NS / `ACDCS_CLK_NS,
	parameter int MS_CYC   = `ACDCS_MS_NS / `ACDCS_CLK_NS
) (
	// clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               clk_en_in,
	// serial bus pins
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe_out,
	// detector results from the analog side
	input  wire acdcs_pkg::acdcs_raw_t detect_raw_in,
	// neighbouring interrupt and timing registers
	input  wire logic               interrupt_mask_bit_in,
	input  wire logic               int_event_in,
	input  wire logic               int_ack_in,
	input  wire logic [3:0]         id_stable_sel_in,
	// pins and analog controls
	output logic                    interrupt_n_out,
	output logic                    factory_jig_n_out,
	output logic                    boot_n_out,
	output logic                    charger_detect_n_out,
	output logic                    vbus_discharge_enable_out,
	output logic [1:0]              overvoltage_threshold_select_out,
	output logic [1:0]              id_float_filter_time_out,
	output logic                    id_fet_overcurrent_disable_out,
	output logic                    id_switch_one_on_out,
	output logic                    id_switch_two_on_out,
	output logic                    id_fet_soft_start_out,
	output logic [4:0]              settled_adc_out,
	output logic                    chip_reset_out
);
	import acdcs_pkg::*;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [14:0] DEGL_M1 = 15'(DEGL_CYC - 1);
	localparam logic [16:0] MS_M1   = 17'(MS_CYC - 1);
	localparam logic [175:0] STAB   = `ACDCS_STABLE_MS;
	localparam acdcs_state_t Q_RST  = '{vctl: `ACDCS_VCTL_RST,
		fctl: `ACDCS_FCTL_RST, scl: 3'h7, sda: 3'h7, st: S_IDLE,
		jig_n: 1'b1, boot_n: 1'b1, chg_n: 1'b1, default: '0};

	acdcs_state_t q;  // registered state
	acdcs_state_t d;  // next state

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	// reserved bits and unmapped offsets read zero
	function automatic logic [7:0] rd_reg(input acdcs_state_t s, input logic [7:0] a);
		case (a)
			`ACDCS_A_VCTL: rd_reg = s.vctl;
			`ACDCS_A_FCTL: rd_reg = s.fctl;
			`ACDCS_A_STS1: rd_reg = {2'h0, s.s2.fm, ~s.chg_n, s.s2.data_contact_timeout_flag,
				s.uv_f, 1'b0, s.ov_f};
			`ACDCS_A_STS2: rd_reg = {1'b0, s.s2.usb, 2'h0, s.s2.idst};
			`ACDCS_A_ADC:  rd_reg = {3'h0, s.adc_set};
			default:       rd_reg = 8'h00;  // also device type four and reset
		endcase
	endfunction : rd_reg

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic       rise;
		logic       fall;
		logic       start;
		logic       stop;
		logic       tick;
		logic       wr;
		logic [7:0] wd;
		logic [10:0] tgt;
		d     = q;
		wr    = 1'b0;
		wd    = q.sh;
		// pins pass two flops before use; stage one feeds stage two only
		d.s1  = detect_raw_in;
		d.s2  = q.s1;
		d.scl = {q.scl[1], q.scl[0], scl_in};
		d.sda = {q.sda[1], q.sda[0], sda_in};
		rise  = q.scl[1] & ~q.scl[2];
		fall  = ~q.scl[1] & q.scl[2];
		start = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
		stop  = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
		tick  = (q.ms_div == MS_M1);
		tgt   = STAB[id_stable_sel_in*11 +: 11];

		// byte serial slave, pointer auto-increments
		if (start) begin
			d.st  = S_ADDR;
			d.cnt = 4'h0;
			d.oe  = 1'b0;
		end else if (stop) begin
			d.st = S_IDLE;
			d.oe = 1'b0;
		end else if (rise) begin
			// sample on rising clock
			if (q.st == S_RACK)
				d.nack = q.sda[1];
			else if (q.st != S_IDLE && q.st != S_AACK && q.st != S_PACK && q.st != S_WACK) begin
				d.sh  = {q.sh[6:0], q.sda[1]};
				d.cnt = q.cnt + 4'h1;
			end
		end else if (fall) begin
			// drive on falling clock
			case (q.st)
				S_ADDR: if (q.cnt == `ACDCS_BITS) begin
					d.cnt = 4'h0;
					d.rw  = q.sh[0];
					d.st  = (q.sh[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
					d.oe  = (q.sh[7:1] == DEV_ADDR);
				end
				S_AACK: begin
					d.tx = rd_reg(q, q.ptr);
					d.st = q.rw ? S_RD : S_PTR;
					d.oe = q.rw & ~d.tx[7];
				end
				S_PTR: if (q.cnt == `ACDCS_BITS) begin
					d.cnt = 4'h0;
					d.ptr = q.sh;
					d.st  = S_PACK;
					d.oe  = 1'b1;
				end
				S_PACK, S_WACK: begin
					d.st = S_WR;
					d.oe = 1'b0;
				end
				S_WR: if (q.cnt == `ACDCS_BITS) begin
					d.cnt = 4'h0;
					wr    = 1'b1;
					d.ptr = q.ptr + 8'h01;
					d.st  = S_WACK;
					d.oe  = 1'b1;
				end
				S_RD: if (q.cnt == `ACDCS_BITS) begin
					d.cnt = 4'h0;
					d.ptr = q.ptr + 8'h01;
					d.st  = S_RACK;
					d.oe  = 1'b0;
				end else begin
					d.oe = ~q.tx[3'h7 - q.cnt[2:0]];
				end
				S_RACK: begin
					// master nack ends the read burst
					d.tx = rd_reg(q, q.ptr);
					d.st = q.nack ? S_IDLE : S_RD;
					d.oe = ~q.nack & ~d.tx[7];
				end
				default: d.oe = 1'b0;
			endcase
		end

		// register writes; a soft reset pulse restores defaults next cycle
		if (q.rst_bit) begin
			d.vctl    = `ACDCS_VCTL_RST;
			d.fctl    = `ACDCS_FCTL_RST;
			d.rst_bit = 1'b0;
		end else if (wr) begin
			case (q.ptr)
				`ACDCS_A_VCTL: d.vctl = wd & `ACDCS_VCTL_WM;
				`ACDCS_A_FCTL: d.fctl = wd & `ACDCS_FCTL_WM;
				`ACDCS_A_RST:  d.rst_bit = wd[`ACDCS_RST_BIT];
				default: ;  // read-only and unmapped writes ignored
			endcase
		end

		// vbus fault deglitch: counter saturates, flag needs it full
		d.uv_cnt = q.s2.uv ? ((q.uv_cnt == DEGL_M1) ? q.uv_cnt : q.uv_cnt + 15'h1) : 15'h0;
		d.ov_cnt = q.s2.ov ? ((q.ov_cnt == DEGL_M1) ? q.ov_cnt : q.ov_cnt + 15'h1) : 15'h0;
		d.uv_f   = q.s2.uv & (q.uv_cnt == DEGL_M1);
		d.ov_f   = q.s2.ov & (q.ov_cnt == DEGL_M1);

		// millisecond time base shared by settle and soft-start
		d.ms_div = tick ? 17'h0 : q.ms_div + 17'h1;

		// settled conversion: value must hold for the stable time
		if (q.s2.adc != q.adc_cand) begin
			d.adc_cand = q.s2.adc;
			d.stab_ms  = 11'h0;
		end else if (q.stab_ms >= tgt) begin
			d.adc_set = q.adc_cand;
		end else if (tick) begin
			d.stab_ms = q.stab_ms + 11'h1;
		end

		// fet only in factory mode, ramped for 32 ms after turn-on
		d.fet_on = q.s2.fm & q.s2.fet_req;
		if (!q.fet_on)
			d.ss_ms = 6'h0;
		else if (tick && q.ss_ms != `ACDCS_SOFT_MS)
			d.ss_ms = q.ss_ms + 6'h1;

		// pin drivers follow detection, factory outputs gated by mode
		d.jig_n  = ~(q.s2.fm & q.s2.jig_req);
		d.boot_n = ~(q.s2.fm & q.s2.boot_req);
		d.chg_n  = ~(q.s2.usb == `ACDCS_USB_DCP ||
			q.s2.usb == `ACDCS_USB_CDP);

		// interrupt: low from power-up until mask written zero
		d.armed = q.armed | ~interrupt_mask_bit_in;
		d.pend  = int_event_in | (q.pend & ~int_ack_in);
		d.intn  = d.armed & ~(d.pend & ~interrupt_mask_bit_in);
	end

	// ----------------------------------------------------------------
	// state register, frozen while the enable is low
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			q <= Q_RST;
		else if (clk_en_in)
			q <= d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sda_out                          = 1'b0;  // open drain
	assign sda_oe_out                       = q.oe;
	assign interrupt_n_out                  = q.intn;
	assign factory_jig_n_out                = q.jig_n;
	assign boot_n_out                       = q.boot_n;
	assign charger_detect_n_out             = q.chg_n;
	assign vbus_discharge_enable_out        = q.vctl[`ACDCS_VCTL_DIS];
	assign overvoltage_threshold_select_out = q.vctl[`ACDCS_VCTL_OVP];
	assign id_float_filter_time_out         = q.vctl[`ACDCS_VCTL_FLT];
	assign id_fet_overcurrent_disable_out   = q.fctl[`ACDCS_FCTL_OCP];
	assign id_switch_one_on_out             = q.fet_on & q.fctl[`ACDCS_FCTL_EN1];
	assign id_switch_two_on_out             = q.fet_on & q.fctl[`ACDCS_FCTL_EN2];
	assign id_fet_soft_start_out            = q.fet_on & (q.ss_ms != `ACDCS_SOFT_MS);
	assign settled_adc_out                  = q.adc_set;
	assign chip_reset_out                   = q.rst_bit;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic [10:0] tgt_chk;  // helper for the settle check, same table as the logic
	assign tgt_chk = STAB[id_stable_sel_in*11 +: 11];

	sequence seq_armed_event;
		q.armed && !interrupt_mask_bit_in && int_event_in;
	endsequence
	sequence seq_int_low;
		!q.intn;
	endsequence

	AST_INT_LOW_UNARMED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!q.armed |-> !interrupt_n_out) else $error("interrupt high before unmask");
	AST_EVENT_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
		seq_armed_event |=> seq_int_low) else $error("event did not pull interrupt low");
	AST_MASK_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
		q.armed && interrupt_mask_bit_in |=> interrupt_n_out) else $error("masked interrupt low");
	AST_SELF_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
		q.rst_bit |=> !q.rst_bit && q.vctl == `ACDCS_VCTL_RST && q.fctl == `ACDCS_FCTL_RST)
		else $error("soft reset not self clearing");
	AST_UV_DEGLITCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(q.uv_f) |-> $past(q.uv_cnt) == DEGL_M1) else $error("undervoltage flag early");
	AST_JIG_FACTORY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(q.jig_n) |-> $past(q.s2.fm)) else $error("jig outside factory mode");
	AST_CHG_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
		q.s2.usb == `ACDCS_USB_CDP |=> !charger_detect_n_out) else $error("charger pin not low");
	AST_FET_FACTORY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(q.fet_on) |-> $past(q.s2.fm) && q.ss_ms == 6'h0) else $error("fet on outside factory");
	AST_ADC_SETTLED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(q.adc_set) |-> $past(q.stab_ms) >= $past(tgt_chk)) else $error("adc published early");
endmodule : acdcs_top
`default_nettype wire
